// File: design/dram_ctrl_end.sv
/*
 dram controller end: mode-1 access sequencing for four banks, automatic refresh,
 precharge wait states and transfer acknowledge.
 assumes the glue end drives a registered access_request and a decoded chip_select.
*/
// Function
// - host drives address, then address strobe
// - chip select decoded from upper address
// - external access request starts each cycle
// - assert row strobe of selected bank
// - after row hold, column address then strobe
// - acknowledge during access; glue makes size ack
// - refresh in progress delays access until precharged
// - back-to-back same bank waits for precharge
// - low address bits should drive bank select
// - up to 16 MHz with one wait
// - delay clock multiple of 2 MHz
// - chip select delayed exactly one clock
// - access strobe registered, doubles as request
// - chip select combinational
// - data ready combinational
// - byte lane column enables combinational
// - glue inputs as listed
// - host clock inverted against controller clock
// - page hit holds request, miss ends burst
// - refresh request every 15 microseconds
`timescale 1ns/1ps
`include "dram_glue_defs.svh"
module dram_ctrl_end import dram_glue_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	dram_glue_if.ctrl link,
	output logic [3:0] row_strobe_n,
	output logic [1:0] column_strobe_n,
	output logic [`ROWCOL_W-1:0] dram_multiplexed_address,
	output logic refresh_busy
);
	localparam int REFRESH_W = $clog2(`REFRESH_CYCLES + 1);
	ctrl_state_t state_ff, nxt_state;
	logic [REFRESH_W-1:0] refresh_cnt_ff;
	logic refresh_pending_ff;
	logic [3:0] wait_cnt_ff;
	logic [1:0] bank_ff;
	logic last_bank_valid_ff;
	logic [1:0] last_bank_ff;
	logic start_access;
	logic same_bank_stall;
	logic wait_done;
	logic take_access;
	logic [1:0] row_bank;

	// interval timer raises the internal refresh request
	always_ff @(posedge clk) begin
		if (reset) begin
			refresh_cnt_ff <= '0;
		end else if (refresh_cnt_ff == REFRESH_W'(`REFRESH_CYCLES - 1)) begin
			refresh_cnt_ff <= '0;
		end else begin
			refresh_cnt_ff <= refresh_cnt_ff + 1'b1;
		end
	end

	// set wins over the clear taken when the refresh starts
	always_ff @(posedge clk) begin
		if (reset) begin
			refresh_pending_ff <= 1'b0;
		end else if (refresh_cnt_ff == REFRESH_W'(`REFRESH_CYCLES - 1)) begin
			refresh_pending_ff <= 1'b1;
		end else if (state_ff == ST_REFRESH) begin
			refresh_pending_ff <= 1'b0;
		end
	end

	assign link.refresh_request_in = refresh_pending_ff;
	assign refresh_busy = (state_ff == ST_REFRESH) || (state_ff == ST_PRECH);
	// a request counts only with a settled chip select (mode 1)
	assign start_access = link.access_request && link.chip_select && link.chip_select_delayed;
	// after a refresh every bank is precharging, so any access has to wait
	assign same_bank_stall = !last_bank_valid_ff || (last_bank_ff == link.bank_select);
	assign wait_done = (wait_cnt_ff == 4'h0);
	// an access is taken from idle, or from precharge when it targets another bank
	assign take_access = (nxt_state == ST_ROW) && (state_ff != ST_ROW);
	assign row_bank = take_access ? link.bank_select : bank_ff;

	// refresh wins over a waiting access; the access simply stays requested
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (refresh_pending_ff) begin
					nxt_state = ST_REFRESH;
				end else if (start_access) begin
					nxt_state = ST_ROW;
				end
			end
			ST_ROW: begin
				if (wait_done) begin
					nxt_state = ST_COL;
				end
			end
			ST_COL: begin
				nxt_state = ST_HOLD;
			end
			ST_HOLD: begin
				if (!link.access_request) begin
					nxt_state = ST_PRECH;
				end
			end
			ST_PRECH: begin
				if (wait_done) begin
					nxt_state = ST_IDLE;
				end else if (!refresh_pending_ff && start_access && !same_bank_stall) begin
					nxt_state = ST_ROW;
				end
			end
			ST_REFRESH: begin
				if (wait_done) begin
					nxt_state = ST_PRECH;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// one counter times row hold, refresh strobe and precharge
	always_ff @(posedge clk) begin
		if (reset) begin
			wait_cnt_ff <= 4'h0;
		end else if (state_ff != nxt_state) begin
			case (nxt_state)
				ST_ROW: wait_cnt_ff <= 4'(`ROW_HOLD_CYCLES - 1);
				ST_REFRESH: wait_cnt_ff <= 4'(`REFRESH_RAS_CYCLES - 1);
				ST_PRECH: wait_cnt_ff <= 4'(`PRECHARGE_CYCLES - 1);
				default: wait_cnt_ff <= 4'h0;
			endcase
		end else if (!wait_done) begin
			wait_cnt_ff <= wait_cnt_ff - 4'h1;
		end
	end

	// only the last bank needs precharge, or every bank after a refresh; other banks may start at once
	always_ff @(posedge clk) begin
		if (reset) begin
			bank_ff <= 2'h0;
			last_bank_ff <= 2'h0;
			last_bank_valid_ff <= 1'b0;
		end else if (take_access) begin
			bank_ff <= link.bank_select;
		end else if (state_ff == ST_HOLD && nxt_state == ST_PRECH) begin
			last_bank_ff <= bank_ff;
			last_bank_valid_ff <= 1'b1;
		end else if (state_ff == ST_REFRESH) begin
			last_bank_valid_ff <= 1'b0;
		end
	end

	// row strobe: selected bank during access, all banks during refresh
	always_ff @(posedge clk) begin
		if (reset) begin
			row_strobe_n <= 4'hF;
		end else begin
			case (nxt_state)
				ST_ROW, ST_COL, ST_HOLD: row_strobe_n <= ~(4'h1 << row_bank);
				ST_REFRESH: row_strobe_n <= 4'h0;
				default: row_strobe_n <= 4'hF;
			endcase
		end
	end

	// address switches to column one cycle before the column strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			dram_multiplexed_address <= '0;
		end else if (take_access) begin
			dram_multiplexed_address <= link.address[`ADDR_W-1:`ROWCOL_W];
		end else if (nxt_state == ST_COL) begin
			dram_multiplexed_address <= link.address[`ROWCOL_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			column_strobe_n <= 2'h3;
		end else if (state_ff == ST_COL || state_ff == ST_HOLD) begin
			column_strobe_n <= ~{link.upper_byte_column_enable,
				link.lower_byte_column_enable};
		end else begin
			column_strobe_n <= 2'h3;
		end
	end

	// acknowledge in the column phase gives one wait state at the host
	always_ff @(posedge clk) begin
		if (reset) begin
			link.transfer_acknowledge <= 1'b0;
		end else begin
			link.transfer_acknowledge <= (nxt_state == ST_HOLD);
		end
	end
endmodule : dram_ctrl_end

// File: design/dram_glue_defs.svh
/*
 header of timing constants and field positions for the dram access glue.
 assumes a single 100 MHz clock; included by bare name.
*/
`ifndef DRAM_GLUE_DEFS_SVH
`define DRAM_GLUE_DEFS_SVH
`define CLK_PERIOD_NS 10
`define REFRESH_INTERVAL_NS 15000
`define REFRESH_CYCLES (`REFRESH_INTERVAL_NS / `CLK_PERIOD_NS)
`define ROW_HOLD_CYCLES 1
`define PRECHARGE_CYCLES 2
`define REFRESH_RAS_CYCLES 2
`define ACK_WAIT_CYCLES 1
`define ADDR_W 20
`define ROWCOL_W 10
`define CHIP_SEL_VALUE 2'h3
`define MEM_FC_MASK 3'h7
`define MEM_FC_CPU 3'h7
`endif

// File: design/dram_glue_pkg.sv
/*
 types shared by both ends of the dram access glue.
 assumes the defs header is compiled alongside.
*/
package dram_glue_pkg;
	typedef enum {ST_IDLE, ST_ROW, ST_COL, ST_HOLD, ST_PRECH, ST_REFRESH} ctrl_state_t;
endpackage : dram_glue_pkg

// File: design/dram_glue_if.sv
/*
 link between the host glue logic and the dram controller end.
 assumes one common clock drives both ends.
*/
`timescale 1ns/1ps
`include "dram_glue_defs.svh"
interface dram_glue_if;
	logic access_request;
	logic chip_select;
	logic chip_select_delayed;
	logic [1:0] bank_select;
	logic [`ADDR_W-1:0] address;
	logic upper_byte_column_enable;
	logic lower_byte_column_enable;
	logic transfer_acknowledge;
	logic refresh_request_in;
	modport ctrl (input access_request, input chip_select, input chip_select_delayed,
		input bank_select, input address, input upper_byte_column_enable,
		input lower_byte_column_enable, output transfer_acknowledge, output refresh_request_in);
	modport glue (output access_request, output chip_select, output chip_select_delayed,
		output bank_select, output address, output upper_byte_column_enable,
		output lower_byte_column_enable, input transfer_acknowledge, input refresh_request_in);
endinterface : dram_glue_if

// File: design/dram_host_glue.sv
/*
 host-side glue: decodes chip select, registers the access strobe, makes byte lane
 column enables and the data-ready answer to the processor.
 assumes processor inputs are synchronous to clk (its clock inverted externally).
*/
`timescale 1ns/1ps
`include "dram_glue_defs.svh"
module dram_host_glue import dram_glue_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] decoded_address,
	input wire logic [2:0] function_code,
	input wire logic upper_byte_strobe_n,
	input wire logic lower_byte_strobe_n,
	input wire logic host_address_strobe_n,
	input wire logic page_hit,
	input wire logic [`ADDR_W-1:0] host_address,
	output logic data_ready_n,
	output logic [1:0] host_size_acknowledge_n,
	dram_glue_if.glue link
);
	logic chip_select_delayed_ff;
	logic access_strobe_ff;
	logic chip_select;
	logic strobe_seen_ff;

	// upper address decode with no clocked delay
	assign chip_select = (decoded_address == `CHIP_SEL_VALUE)
		&& ((function_code & `MEM_FC_MASK) != `MEM_FC_CPU);
	assign link.chip_select = chip_select;
	assign link.address = host_address;
	assign link.bank_select = host_address[1:0];

	always_ff @(posedge clk) begin
		if (reset) begin
			chip_select_delayed_ff <= 1'b0;
		end else begin
			chip_select_delayed_ff <= chip_select;
		end
	end
	assign link.chip_select_delayed = chip_select_delayed_ff;

	// a page miss drops the request to end a burst
	always_ff @(posedge clk) begin
		if (reset) begin
			access_strobe_ff <= 1'b0;
		end else begin
			access_strobe_ff <= chip_select && !host_address_strobe_n
				&& (page_hit || !access_strobe_ff);
		end
	end
	assign link.access_request = access_strobe_ff;

	assign link.upper_byte_column_enable = !upper_byte_strobe_n && chip_select;
	assign link.lower_byte_column_enable = !lower_byte_strobe_n && chip_select;
	// a fresh strobe must not see the acknowledge left over from the previous cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			strobe_seen_ff <= 1'b0;
		end else begin
			strobe_seen_ff <= !host_address_strobe_n;
		end
	end
	assign data_ready_n = !(link.transfer_acknowledge && !host_address_strobe_n
		&& strobe_seen_ff);
	assign host_size_acknowledge_n = {2{data_ready_n}};
endmodule : dram_host_glue

// File: dv/dram_glue_asserts.sv
/* checker on the link between glue and controller ends.
 assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "dram_glue_defs.svh"
module dram_glue_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic access_request,
	input wire logic chip_select,
	input wire logic chip_select_delayed,
	input wire logic transfer_acknowledge,
	input wire logic refresh_request_in
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [4:0] wait_ff;
	logic [11:0] gap_ff;
	// cycles a request has waited unanswered
	always_ff @(posedge clk) begin
		if (reset || !access_request || transfer_acknowledge)
			wait_ff <= 5'h00;
		else if (wait_ff != 5'h1F)
			wait_ff <= wait_ff + 5'h01;
	end
	always_ff @(posedge clk) begin
		if (reset || refresh_request_in)
			gap_ff <= 12'h000;
		else if (gap_ff != 12'hFFF)
			gap_ff <= gap_ff + 12'h001;
	end
	property p_csd; !$past(reset) |-> chip_select_delayed == $past(chip_select); endproperty
	a_csd: assert property (p_csd) else $error("delayed select wrong");
	property p_req; $rose(access_request) |-> $past(chip_select); endproperty
	a_req: assert property (p_req) else $error("request without select");
	property p_ack; $rose(transfer_acknowledge) |-> $past(access_request); endproperty
	a_ack: assert property (p_ack) else $error("ack without request");
	property p_drop; !access_request |=> !transfer_acknowledge; endproperty
	a_drop: assert property (p_drop) else $error("ack outlived request");
	// covers a refresh plus precharge ahead of a one-wait access
	property p_wait; wait_ff <= 5'h0E; endproperty
	a_wait: assert property (p_wait) else $error("access waited too long");
	property p_gap; gap_ff <= `REFRESH_CYCLES; endproperty
	a_gap: assert property (p_gap) else $error("refresh interval overrun");
	property p_ref; $fell(refresh_request_in) |-> !transfer_acknowledge [*3]; endproperty
	a_ref: assert property (p_ref) else $error("access inside refresh");
	property p_pre; $fell(transfer_acknowledge) |-> !transfer_acknowledge [*3]; endproperty
	a_pre: assert property (p_pre) else $error("precharge cut short");
endmodule : dram_glue_asserts

// File: dv/host_dram_access_glue_bench.sv
/* bench joining host glue and controller end, checked through a note queue.
 assumes defs header and package are compiled first. */
`timescale 1ns/1ps
`include "dram_glue_defs.svh"
module host_dram_access_glue_bench import dram_glue_pkg::*; ;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] decoded_address = 2'h0;
	logic [2:0] function_code = 3'h0;
	logic upper_byte_strobe_n = 1'b1;
	logic lower_byte_strobe_n = 1'b1;
	logic host_address_strobe_n = 1'b1;
	logic page_hit = 1'b0;
	logic [19:0] host_address = 20'h00000;
	logic data_ready_n;
	logic [1:0] host_size_acknowledge_n;
	logic [3:0] row_strobe_n;
	logic [1:0] column_strobe_n;
	logic [`ROWCOL_W-1:0] dram_multiplexed_address;
	logic refresh_busy;
	logic refresh_seen = 1'b0;
	int failures = 0;
	int comparisons = 0;
	logic [15:0] notes[$];
	dram_glue_if link ();
	dram_host_glue u_dram_host_glue (.clk(clk), .reset(reset),
		.decoded_address(decoded_address), .function_code(function_code),
		.upper_byte_strobe_n(upper_byte_strobe_n), .lower_byte_strobe_n(lower_byte_strobe_n),
		.host_address_strobe_n(host_address_strobe_n), .page_hit(page_hit),
		.host_address(host_address), .data_ready_n(data_ready_n),
		.host_size_acknowledge_n(host_size_acknowledge_n), .link(link));
	dram_ctrl_end u_dram_ctrl_end (.clk(clk), .reset(reset), .link(link),
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.dram_multiplexed_address(dram_multiplexed_address), .refresh_busy(refresh_busy));
	dram_glue_asserts u_dram_glue_asserts (.clk(clk), .reset(reset),
		.access_request(link.access_request), .chip_select(link.chip_select),
		.chip_select_delayed(link.chip_select_delayed),
		.transfer_acknowledge(link.transfer_acknowledge),
		.refresh_request_in(link.refresh_request_in));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wrap_up;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task access(input logic [1:0] bk, input logic [1:0] dec, input logic [2:0] fc,
		input logic [1:0] lanes);
		logic sel;
		int n;
		sel = dec == `CHIP_SEL_VALUE && fc != `MEM_FC_CPU;
		@(negedge clk);
		host_address = {18'($urandom()), bk};
		decoded_address = dec;
		function_code = fc;
		{upper_byte_strobe_n, lower_byte_strobe_n} = lanes;
		host_address_strobe_n = 1'b0;
		page_hit = 1'b1;
		if (sel)
			notes.push_back({~(4'h1 << bk), lanes, host_address[`ROWCOL_W-1:0]});
		// refused selects simply run out this wait; the first look is one edge later
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (n < 20 && data_ready_n !== 1'b0);
		if (sel && data_ready_n !== 1'b0) begin
			failures++;
			wrap_up();
		end
		@(negedge clk);
		host_address_strobe_n = 1'b1;
		{upper_byte_strobe_n, lower_byte_strobe_n} = 2'h3;
		page_hit = 1'b0;
	endtask : access
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		logic [15:0] exp;
		logic prev;
		prev = 1'b1;
		forever begin
			@(posedge clk);
			#1;
			if (link.refresh_request_in === 1'b1)
				refresh_seen = 1'b1;
			if (data_ready_n === 1'b0 && prev) begin
				if (notes.size() == 0)
					check(16'h0000, 16'hFFFF);
				else begin
					exp = notes.pop_front();
					check({14'h0000, host_size_acknowledge_n}, 16'h0000);
					check({15'h0000, refresh_busy}, 16'h0000);
					@(posedge clk);
					#1;
					check({10'h000, row_strobe_n, column_strobe_n}, {10'h000, exp[15:10]});
					check({6'h00, dram_multiplexed_address}, {6'h00, exp[9:0]});
				end
			end
			prev = data_ready_n;
		end
	end
	initial begin
		int b;
		int l;
		int i;
		i = $urandom(32'h1769FDFC);
		repeat (4) @(negedge clk);
		reset = 1'b0;
		for (b = 0; b < 4; b++)
			for (l = 0; l < 3; l++)
				access(b[1:0], `CHIP_SEL_VALUE, 3'h5, 2'(l));
		$display("test banks and lanes done");
		for (b = 0; b < 3; b++)
			access(2'h0, b[1:0], 3'h5, 2'h0);
		access(2'h1, `CHIP_SEL_VALUE, `MEM_FC_CPU, 2'h0);
		$display("test refused selects done");
		repeat (3) access(2'h2, `CHIP_SEL_VALUE, 3'h1, 2'h0);
		$display("test same bank back to back done");
		for (i = 0; i < 300; i++)
			access(2'($urandom()), 2'($urandom()), 3'($urandom()), 2'($urandom_range(2)));
		check({15'h0000, refresh_seen}, 16'h0001);
		$display("test random traffic across refresh done");
		wrap_up();
	end
endmodule : host_dram_access_glue_bench
